// ---- verilog/hotplug_consts.vh ----
// constants for the hot plug memory-space register bank
`ifndef HOTPLUG_CONSTS_VH
`define HOTPLUG_CONSTS_VH

// decoded window behind the memory base, 64 bytes
`define WIN_ADDR_BITS 6
// dword offsets (byte address bits 5:2 of each 32-bit lane group)
`define DW_TIMER_REQ_MISC 4'h0
`define DW_LAMP 4'h1
`define DW_IRQ_CLEAR 4'h2
`define DW_IRQ_MASK 4'h3
`define DW_SCAN_GPO 4'h4
`define DW_PLAIN_IN 4'h5
`define DW_SLOT_ID 4'hA
`define DW_REDIR_SUPPLY 4'hB
`define DW_EXT_MISC 4'hC

// printed byte offsets of the narrow registers
`define OFF_TIMER 6'h00
`define OFF_SLOT_REQ 6'h01
`define OFF_MISC 6'h02
`define OFF_GPO 6'h13
`define OFF_SLOT_ID 6'h28
`define OFF_REDIRECT 6'h2C
`define OFF_SUPPLY 6'h2D
`define OFF_EXT_MISC 6'h32

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define RST_IRQ_MASK 32'h0000_00FF
`define RST_MISC 16'h0000

// misc configuration field positions
`define MISC_GO 0
`define MISC_BUSY 8
`define MISC_PFE 10
`define MISC_LATCH_VIEW 13
`define MISC_SYSERR 14
// plain read/write storage bits of misc config (12,9,6,4)
`define MISC_RW_MASK 16'h1250
`define MISC_ZERO_MASK 16'h8000
// storable bits of each misc byte: plain bits and the three enables
`define MISC_LO_WR 8'h50
`define MISC_HI_WR 8'h76

// slot enable field
`define SLOT_COUNT 6
`define SLOT_REQ_MASK 8'h3F

// power fault byte inside the interrupt input register
`define IRQ_FAULT_LSB 16
`define IRQ_FAULT_BYTE_ONES 8'hFF

// sequencer phases
`define CLK_PERIOD_NS 10
`define PHASE_TIME_NS 1000
`define PHASE_CYCLES ((`PHASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_CNT_W 8

`endif

// ---- verilog/slot_power_ctrl.v ----
// four control outputs of one slot, stepped by the shared sequencer
`timescale 1ns/1ps
`default_nettype none
module slot_power_ctrl (
  input wire clk,
  input wire rst_n,
  input wire step_fire,
  input wire step_on,
  input wire [1:0] step_num,
  input wire selected,
  output reg slot_supply_on,
  output reg slot_clock_on_n,
  output reg slot_bus_connect_n,
  output reg slot_reset_n
);
  // slot comes out of reset fully off and held in reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_supply_on <= 1'b0;
      slot_clock_on_n <= 1'b1;
      slot_bus_connect_n <= 1'b1;
      slot_reset_n <= 1'b0;
    end else if (step_fire && selected) begin
      if (step_on) begin
        case (step_num)
          2'd0: slot_supply_on <= 1'b1;
          2'd1: slot_clock_on_n <= 1'b0;
          2'd2: slot_bus_connect_n <= 1'b0;
          default: slot_reset_n <= 1'b1;
        endcase
      end else begin
        case (step_num)
          2'd0: slot_reset_n <= 1'b0;
          2'd1: slot_bus_connect_n <= 1'b1;
          2'd2: slot_clock_on_n <= 1'b1;
          default: slot_supply_on <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/hot_plug_slot_control_regs.v ----
// hot plug memory-space register bank with slot on/off sequencer
//
// What this block does
// - decode window at memory base from config
// - offset zero timer: plain 8-bit store
// - interrupt mask low byte resets to ones
// - interrupt input bits clear on written one
// - slot enables act only after go write
// - enable 0 to 1 powers slot up
// - enable 1 to 0 powers slot down
// - disables finish before enables start
// - enable cannot be set while switch open
// - slot enable reads stored value always
// - slots A-F on bits 0-5, 7:6 reserved
// - only strapped-in slots are writable
// - misc config bit 15 reads zero
// - faults interrupt through mask independently
// - latch view shows latched fault bits
// - latch view without fault enable reads ones
// - busy bit set while sequencer runs
`timescale 1ns/1ps
`default_nettype none
`include "hotplug_consts.vh"
module hot_plug_slot_control_regs (
  input wire clk,
  input wire rst_n,
  input wire [31:0] mem_base_low,
  input wire [31:0] mem_base_high,
  input wire [31:0] mem_addr_low,
  input wire [31:0] mem_addr_high,
  input wire mem_wr,
  input wire mem_rd,
  input wire [3:0] mem_be,
  input wire [31:0] mem_wdata,
  output wire mem_hit,
  output reg [31:0] mem_rdata,
  output reg mem_rdata_valid,
  input wire [2:0] slot_count_straps,
  input wire [5:0] slot_switch_open,
  input wire [5:0] slot_power_fault,
  input wire [31:0] irq_source_events,
  input wire [31:0] plain_inputs,
  input wire serr_enable,
  output wire syserr_assert,
  output wire hotplug_irq,
  output wire sequencer_busy,
  output wire [5:0] slot_supply_on,
  output wire [5:0] slot_clock_on_n,
  output wire [5:0] slot_bus_connect_n,
  output wire [5:0] slot_reset_n
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_OFF = 2'd1;
  localparam [1:0] S_ON = 2'd2;
  localparam [31:0] PHASE_LAST_W = `PHASE_CYCLES - 1;
  localparam [`PHASE_CNT_W-1:0] PHASE_LAST = PHASE_LAST_W[`PHASE_CNT_W-1:0];

  reg [7:0] legacy_timer_scratch_q;
  reg [7:0] slot_power_request_q;
  reg [15:0] misc_store_q;
  reg [31:0] indicator_lamp_control_q;
  reg [31:0] irq_pending_q;
  reg [5:0] fault_latch_q;
  reg [31:0] hotplug_irq_mask_q;
  reg [15:0] scan_input_control_q;
  reg [7:0] general_output_bits_q;
  reg [7:0] slot_identifier_q;
  reg [7:0] switch_irq_redirect_q;
  reg [7:0] slot_supply_enable_q;
  reg [15:0] hotplug_extended_misc_q;
  reg [5:0] strap_slots_q;
  reg strap_taken_q;
  reg [5:0] applied_q;
  reg [5:0] off_group_q;
  reg [5:0] on_group_q;
  reg [1:0] state_q;
  reg [1:0] step_q;
  reg [`PHASE_CNT_W-1:0] cnt_q;

  wire [3:0] dw;
  wire wr;
  wire [7:0] req_d;
  wire [5:0] req_wr_ok;
  wire go_write;
  wire [5:0] turn_off;
  wire [5:0] turn_on;
  wire power_fault_enable;
  wire latch_view;
  wire step_fire;
  wire phase_end;
  wire [7:0] fault_byte;
  wire [31:0] irq_view;
  wire [31:0] irq_set;
  wire [31:0] irq_clr;
  wire [15:0] misc_view;
  reg [31:0] rd_word;
  genvar g;

  // 64-bit base; the window is aligned to its own size
  assign mem_hit = ({mem_addr_high, mem_addr_low[31:`WIN_ADDR_BITS]} ==
    {mem_base_high, mem_base_low[31:`WIN_ADDR_BITS]});
  assign dw = mem_addr_low[`WIN_ADDR_BITS-1:2];
  assign wr = mem_wr && mem_hit;

  // byte-enable merge of a written word into a stored one
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[8*i +: 8] = data[8*i +: 8];
        end
      end
    end
  endfunction

  // straps caught once after reset release, never under the async reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_q <= 1'b0;
      strap_slots_q <= 6'h00;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      case (slot_count_straps)
        3'd1: strap_slots_q <= 6'h01;
        3'd2: strap_slots_q <= 6'h03;
        3'd3: strap_slots_q <= 6'h07;
        3'd4: strap_slots_q <= 6'h0F;
        3'd5: strap_slots_q <= 6'h1F;
        3'd6: strap_slots_q <= 6'h3F;
        default: strap_slots_q <= 6'h00;
      endcase
    end
  end

  // a bit moves only for a strapped slot, and to 1 only if switch closed
  generate
    for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : g_req
      assign req_wr_ok[g] = strap_slots_q[g] &&
        (!mem_wdata[8+g] || !slot_switch_open[g]);
      assign req_d[g] = (wr && mem_be[1] && dw == `DW_TIMER_REQ_MISC &&
        req_wr_ok[g]) ? mem_wdata[8+g] : slot_power_request_q[g];
    end
  endgenerate
  assign req_d[7:6] = 2'b00;

  assign go_write = wr && mem_be[2] && dw == `DW_TIMER_REQ_MISC &&
    mem_wdata[16+`MISC_GO];
  // the go write uses the enables as they stand after this same write
  assign turn_off = applied_q & ~req_d[5:0];
  assign turn_on = ~applied_q & req_d[5:0];

  assign power_fault_enable = misc_store_q[`MISC_PFE];
  assign latch_view = misc_store_q[`MISC_LATCH_VIEW];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_timer_scratch_q <= `RST_BYTE;
      slot_power_request_q <= `RST_BYTE;
      misc_store_q <= `RST_MISC;
      indicator_lamp_control_q <= `RST_WORD;
      hotplug_irq_mask_q <= `RST_IRQ_MASK;
      scan_input_control_q <= 16'h0000;
      general_output_bits_q <= `RST_BYTE;
      slot_identifier_q <= `RST_BYTE;
      switch_irq_redirect_q <= `RST_BYTE;
      slot_supply_enable_q <= `RST_BYTE;
      hotplug_extended_misc_q <= 16'h0000;
    end else begin
      slot_power_request_q <= req_d;
      if (wr) begin
        case (dw)
          `DW_TIMER_REQ_MISC: begin
            if (mem_be[0]) begin
              legacy_timer_scratch_q <= mem_wdata[7:0];
            end
            if (mem_be[2]) begin
              misc_store_q[7:0] <= mem_wdata[23:16] & `MISC_LO_WR;
            end
            if (mem_be[3]) begin
              misc_store_q[15:8] <= mem_wdata[31:24] & `MISC_HI_WR;
            end
          end
          `DW_LAMP: indicator_lamp_control_q <= merge(
            indicator_lamp_control_q, mem_wdata, mem_be);
          `DW_IRQ_MASK: hotplug_irq_mask_q <= merge(
            hotplug_irq_mask_q, mem_wdata, mem_be);
          `DW_SCAN_GPO: begin
            if (mem_be[0]) begin
              scan_input_control_q[7:0] <= mem_wdata[7:0];
            end
            if (mem_be[1]) begin
              scan_input_control_q[15:8] <= mem_wdata[15:8];
            end
            if (mem_be[3]) begin
              general_output_bits_q <= mem_wdata[31:24];
            end
          end
          `DW_SLOT_ID: begin
            if (mem_be[0]) begin
              slot_identifier_q <= mem_wdata[7:0];
            end
          end
          `DW_REDIR_SUPPLY: begin
            if (mem_be[0]) begin
              switch_irq_redirect_q <= mem_wdata[7:0];
            end
            if (mem_be[1]) begin
              slot_supply_enable_q <= mem_wdata[15:8];
            end
          end
          `DW_EXT_MISC: begin
            if (mem_be[2]) begin
              hotplug_extended_misc_q[7:0] <= mem_wdata[23:16];
            end
            if (mem_be[3]) begin
              hotplug_extended_misc_q[15:8] <= mem_wdata[31:24];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // fault latches catch short pulses the raw pins would miss
  assign irq_clr = (wr && dw == `DW_IRQ_CLEAR) ?
    (mem_wdata & {{8{mem_be[3]}}, {8{mem_be[2]}}, {8{mem_be[1]}},
    {8{mem_be[0]}}}) : 32'h0000_0000;
  assign irq_set = {irq_source_events[31:24], 2'b00, slot_power_fault,
    irq_source_events[15:0]};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending_q <= `RST_WORD;
      fault_latch_q <= 6'h00;
    end else begin
      // a new event in the clearing cycle stays set
      irq_pending_q <= (irq_pending_q & ~irq_clr) | irq_set;
      fault_latch_q <= (fault_latch_q & ~irq_clr[21:16]) |
        (slot_power_fault & {6{power_fault_enable}});
    end
  end

  assign fault_byte = !latch_view ? {2'b00, slot_power_fault} :
    !power_fault_enable ? `IRQ_FAULT_BYTE_ONES :
    {2'b00, fault_latch_q};
  assign irq_view = {irq_pending_q[31:24], fault_byte,
    irq_pending_q[15:0]};

  // faults reach the interrupt through the mask alone
  assign hotplug_irq = |(irq_pending_q & ~hotplug_irq_mask_q);

  // clock-on marks the slot as past its clock-connect phase
  assign syserr_assert = misc_store_q[`MISC_SYSERR] && power_fault_enable && serr_enable &&
    |(slot_power_fault & ~slot_clock_on_n);

  // sequencer: one step per phase, each phase held PHASE_CYCLES
  assign step_fire = (state_q != S_IDLE) && (cnt_q == {`PHASE_CNT_W{1'b0}});
  assign phase_end = (cnt_q == PHASE_LAST);
  assign sequencer_busy = (state_q != S_IDLE);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      step_q <= 2'd0;
      cnt_q <= {`PHASE_CNT_W{1'b0}};
      applied_q <= 6'h00;
      off_group_q <= 6'h00;
      on_group_q <= 6'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          // a go write while busy is dropped; software polls busy first
          if (go_write) begin
            off_group_q <= turn_off;
            on_group_q <= turn_on;
            applied_q <= req_d[5:0];
            step_q <= 2'd0;
            cnt_q <= {`PHASE_CNT_W{1'b0}};
            if (|turn_off) begin
              state_q <= S_OFF;
            end else if (|turn_on) begin
              state_q <= S_ON;
            end
          end
        end
        S_OFF, S_ON: begin
          if (!phase_end) begin
            cnt_q <= cnt_q + {{(`PHASE_CNT_W-1){1'b0}}, 1'b1};
          end else begin
            cnt_q <= {`PHASE_CNT_W{1'b0}};
            step_q <= step_q + 2'd1;
            if (step_q == 2'd3) begin
              if (state_q == S_OFF && |on_group_q) begin
                state_q <= S_ON;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  generate
    for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : g_slot
      slot_power_ctrl u_slot (
        .clk(clk),
        .rst_n(rst_n),
        .step_fire(step_fire),
        .step_on(state_q == S_ON),
        .step_num(step_q),
        .selected(state_q == S_ON ? on_group_q[g] : off_group_q[g]),
        .slot_supply_on(slot_supply_on[g]),
        .slot_clock_on_n(slot_clock_on_n[g]),
        .slot_bus_connect_n(slot_bus_connect_n[g]),
        .slot_reset_n(slot_reset_n[g])
      );
    end
  endgenerate

  // go reads back 0, busy reflects the sequencer, bit 15 stays 0
  assign misc_view = (misc_store_q & ~`MISC_ZERO_MASK) |
    ({15'h0000, sequencer_busy} << `MISC_BUSY);

  always @* begin
    rd_word = 32'h0000_0000;
    case (dw)
      `DW_TIMER_REQ_MISC: rd_word = {misc_view, slot_power_request_q,
        legacy_timer_scratch_q};
      `DW_LAMP: rd_word = indicator_lamp_control_q;
      `DW_IRQ_CLEAR: rd_word = irq_view;
      `DW_IRQ_MASK: rd_word = hotplug_irq_mask_q;
      `DW_SCAN_GPO: rd_word = {general_output_bits_q, 8'h00,
        scan_input_control_q};
      `DW_PLAIN_IN: rd_word = plain_inputs;
      `DW_SLOT_ID: rd_word = {24'h000000, slot_identifier_q};
      `DW_REDIR_SUPPLY: rd_word = {16'h0000, slot_supply_enable_q,
        switch_irq_redirect_q};
      `DW_EXT_MISC: rd_word = {hotplug_extended_misc_q, 16'h0000};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= 32'h0000_0000;
      mem_rdata_valid <= 1'b0;
    end else begin
      mem_rdata_valid <= mem_rd && mem_hit;
      if (mem_rd && mem_hit) begin
        mem_rdata <= rd_word;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/hot_plug_props.sv ----
// assertion checker for the hot plug register bank
`timescale 1ns/1ps
`default_nettype none
module hot_plug_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [3:0] mem_be,
  input wire logic mem_hit,
  input wire logic mem_rdata_valid,
  input wire logic serr_enable,
  input wire logic [5:0] slot_power_fault,
  input wire logic syserr_assert,
  input wire logic sequencer_busy,
  input wire logic [5:0] slot_supply_on,
  input wire logic [5:0] slot_clock_on_n,
  input wire logic [5:0] slot_bus_connect_n,
  input wire logic [5:0] slot_reset_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [23:0] outs = {slot_supply_on, slot_clock_on_n,
    slot_bus_connect_n, slot_reset_n};

  read_answer_a: assert property (
    mem_rd && mem_hit |=> mem_rdata_valid)
    else $error("hit read got no answer");
  read_miss_a: assert property (
    !(mem_rd && mem_hit) |=> !mem_rdata_valid)
    else $error("answer without hit read");
  busy_cause_a: assert property (
    $rose(sequencer_busy) |-> $past(mem_wr && mem_hit && mem_be[2]))
    else $error("busy rose without go write");
  step_when_busy_a: assert property (
    !$stable(outs) |-> sequencer_busy)
    else $error("slot output moved while idle");
  first_step_a: assert property (
    $rose(sequencer_busy) |-> ##[1:2] !$stable(outs))
    else $error("busy with no step");
  clock_needs_power_a: assert property (
    (~slot_clock_on_n & ~slot_supply_on) == 6'h00)
    else $error("clock on without power");
  bus_needs_clock_a: assert property (
    (~slot_bus_connect_n & slot_clock_on_n) == 6'h00)
    else $error("bus on without clock");
  reset_needs_bus_a: assert property (
    (slot_reset_n & slot_bus_connect_n) == 6'h00)
    else $error("reset released without bus");
  syserr_gate_a: assert property (
    syserr_assert |-> serr_enable &&
    |(slot_power_fault & ~slot_clock_on_n))
    else $error("syserr without its conditions");

  cover property ($rose(sequencer_busy));
  cover property (syserr_assert);
  cover property (mem_rd && !mem_hit);
endmodule
bind hot_plug_slot_control_regs hot_plug_props u_props (.clk, .rst_n,
  .mem_wr, .mem_rd, .mem_be, .mem_hit, .mem_rdata_valid, .serr_enable,
  .slot_power_fault, .syserr_assert, .sequencer_busy, .slot_supply_on,
  .slot_clock_on_n, .slot_bus_connect_n, .slot_reset_n);
`default_nettype wire

// ---- tb/slot_far_end.sv ----
// far-side slot model: a powered slot can report a supply fault
`timescale 1ns/1ps
`default_nettype none
module slot_far_end (
  input wire logic [5:0] slot_supply_on,
  input wire logic [5:0] fault_cmd,
  output logic [5:0] slot_power_fault
);
  // an unpowered slot has no load, so it cannot fault
  assign slot_power_fault = fault_cmd & slot_supply_on;
endmodule
`default_nettype wire

// ---- tb/test_hot_plug_slot_control_regs.sv ----
// self-checking bench for the hot plug register bank
`timescale 1ns/1ps
`default_nettype none
module test_hot_plug_slot_control_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] base = 32'h0, addr = 32'h0, wdata = 32'h0;
  logic mem_wr = 1'b0, mem_rd = 1'b0, serr_en = 1'b0;
  logic [3:0] be = 4'h0;
  logic [5:0] sw_open = 6'h00, fcmd = 6'h00, fault;
  logic [31:0] events = 32'h0, plain = 32'h0, rdata, got, d;
  logic [15:0] misc = 16'h0000;
  logic hit, rvalid, syserr, irq, busy;
  logic [5:0] sup, clk_n, bus_n, rst_sl;
  int fail_count = 0, n_checks = 0, t_off, t_on, k;

  hot_plug_slot_control_regs dut (.clk(clk), .rst_n(rst_n),
    .mem_base_low(base), .mem_base_high(32'h0), .mem_addr_low(addr),
    .mem_addr_high(32'h0), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_be(be),
    .mem_wdata(wdata), .mem_hit(hit), .mem_rdata(rdata),
    .mem_rdata_valid(rvalid), .slot_count_straps(3'h3),
    .slot_switch_open(sw_open), .slot_power_fault(fault),
    .irq_source_events(events), .plain_inputs(plain),
    .serr_enable(serr_en), .syserr_assert(syserr), .hotplug_irq(irq),
    .sequencer_busy(busy), .slot_supply_on(sup), .slot_clock_on_n(clk_n),
    .slot_bus_connect_n(bus_n), .slot_reset_n(rst_sl));
  slot_far_end far (.slot_supply_on(sup), .fault_cmd(fcmd),
    .slot_power_fault(fault));

  initial forever #5 clk = ~clk;

  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [3:0] b,
                    input logic [31:0] v);
    @(posedge clk);
    addr <= base + a;
    be <= b;
    wdata <= v;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
  endtask

  // answer is registered on the taking edge and read 1 ns after it
  task automatic rd(input logic [31:0] a, input logic v);
    @(posedge clk);
    addr <= base + a;
    mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    #1;
    got = rdata;
    chk({31'h0, rvalid}, {31'h0, v});
    chk({31'h0, hit}, {31'h0, v});
  endtask

  // go write, then follow the sequencer until it goes idle
  task automatic run_go(input logic [5:0] offm, input logic [5:0] onm);
    wr(32'h0, 4'h4, {misc, 16'h0} | 32'h0001_0000);
    rd(32'h00, 1'b1);
    chk({31'h0, got[24]}, 32'h1);
    t_off = -1;
    t_on = -1;
    for (int i = 0; i < 1200; i++) begin
      @(posedge clk);
      #1;
      if (t_off < 0 && (sup & offm) == 6'h00) t_off = i;
      if (t_on < 0 && (sup & onm) != 6'h00) t_on = i;
      if (i > 2 && busy === 1'b0) break;
    end
    chk({31'h0, busy}, 32'h0);
    if (busy !== 1'b0) give_verdict();
  endtask

  // plain read/write words by index, and the bits that each one keeps
  function automatic logic [5:0] rw_off(input int j);
    case (j)
      0: rw_off = 6'h04;
      1: rw_off = 6'h0C;
      2: rw_off = 6'h10;
      3: rw_off = 6'h28;
      4: rw_off = 6'h2C;
      default: rw_off = 6'h30;
    endcase
  endfunction

  function automatic logic [31:0] rw_bits(input logic [5:0] off);
    case (off)
      6'h04, 6'h0C: rw_bits = 32'hFFFF_FFFF;
      6'h10: rw_bits = 32'hFF00_FFFF;
      6'h28: rw_bits = 32'h0000_00FF;
      6'h2C: rw_bits = 32'h0000_FFFF;
      6'h30: rw_bits = 32'hFFFF_0000;
      default: rw_bits = 32'h0000_0000;
    endcase
  endfunction

  initial begin
    void'($urandom(62632));
    @(posedge clk);
    base <= $urandom & 32'hFFFF_FFC0;
    repeat (15) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(32'h00, 1'b1);
    chk(got, 32'h0);
    rd(32'h0C, 1'b1);
    chk(got, 32'h0000_00FF);
    rd(32'h18, 1'b1);
    chk(got, 32'h0);
    rd(32'h40, 1'b0);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      @(posedge clk);
      plain <= ~d;
      wr(32'h00, 4'h1, d);
      rd(32'h00, 1'b1);
      chk(got, {24'h0, d[7:0]});
      rd(32'h14, 1'b1);
      chk(got, ~d);
    end
    for (int j = 0; j < 6; j++) begin
      d = $urandom;
      wr({26'h0, rw_off(j)}, 4'hF, d);
      rd({26'h0, rw_off(j)}, 1'b1);
      chk(got, d & rw_bits(rw_off(j)));
    end
    wr(32'h00, 4'hC, 32'hFFFE_0000);
    rd(32'h00, 1'b1);
    chk(got[31:16], 32'h7650);
    // a low-lane-only write must leave the upper misc byte alone
    wr(32'h00, 4'h4, 32'h0000_0000);
    rd(32'h00, 1'b1);
    chk(got[31:16], 32'h7600);
    wr(32'h00, 4'hC, 32'h0);
    // slot 2 switch open, slots 3..5 not strapped in
    @(posedge clk);
    sw_open <= 6'h04;
    wr(32'h00, 4'h2, 32'hFFFF_FFFF);
    rd(32'h00, 1'b1);
    chk(got[31:8], 32'h0000_0003);
    chk(sup, 32'h0);
    @(posedge clk);
    sw_open <= 6'h00;
    wr(32'h00, 4'h2, 32'h0000_0300);
    run_go(6'h00, 6'h03);
    chk({8'h00, sup, clk_n, bus_n, rst_sl}, 32'h000F_CF03);
    wr(32'h00, 4'h2, 32'h0000_0600);
    run_go(6'h01, 6'h04);
    chk({31'h0, t_off < t_on}, 32'h1);
    chk({8'h00, sup, clk_n, bus_n, rst_sl}, 32'h001B_9E46);
    wr(32'h0C, 4'hF, 32'hFFFD_FFFF);
    misc = 16'h6400;
    wr(32'h00, 4'hC, {misc, 16'h0});
    k = $urandom_range(15, 0);
    @(posedge clk);
    serr_en <= 1'b1;
    fcmd <= 6'h02;
    events <= 32'h1 << k;
    @(posedge clk);
    events <= 32'h0;
    #1;
    chk({31'h0, syserr}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    serr_en <= 1'b0;
    #1;
    chk({31'h0, syserr}, 32'h0);
    @(posedge clk);
    serr_en <= 1'b1;
    fcmd <= 6'h20;
    #1;
    chk({31'h0, syserr}, 32'h0);
    @(posedge clk);
    fcmd <= 6'h00;
    rd(32'h08, 1'b1);
    chk(got, 32'h0002_0000 | (32'h1 << k));
    wr(32'h08, 4'hF, 32'h0002_0000);
    rd(32'h08, 1'b1);
    chk(got, 32'h1 << k);
    wr(32'h08, 4'hF, 32'h1 << k);
    rd(32'h08, 1'b1);
    chk(got, 32'h0);
    chk({31'h0, irq}, 32'h0);
    misc = 16'h2000;
    wr(32'h00, 4'hC, {misc, 16'h0});
    rd(32'h08, 1'b1);
    chk(got[23:16], 32'hFF);
    give_verdict();
  end
endmodule
`default_nettype wire
